/* File: design/eesa_fifo.sv */
// page buffer fifo with valid and ready on both sides
`timescale 1ns/1ps
module eesa_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_ff;
   logic [AW:0]      rd_ptr_ff;

   assign in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW + 1)'(DEPTH);
   assign out_valid = wr_ptr_ff != rd_ptr_ff;
   assign out_data  = mem[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (rst)
         wr_ptr_ff <= '0;
      else if (in_valid && in_ready)
         wr_ptr_ff <= wr_ptr_ff + (AW + 1)'(1);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rd_ptr_ff <= '0;
      else if (out_valid && out_ready)
         rd_ptr_ff <= rd_ptr_ff + (AW + 1)'(1);
   end

   always_ff @(posedge clk)
   begin
      if (in_valid && in_ready)
         mem[wr_ptr_ff[AW-1:0]] <= in_data;
   end
endmodule : eesa_fifo

/* File: design/eesa_if.sv */
// two-wire bus joining the memory end and the bus master end
`timescale 1ns/1ps
interface eesa_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;

   // open-drain data line with pull-up
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
   modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
endinterface : eesa_if

/* File: design/eesa_master.sv */
// bus master end: single byte write and random single byte read
`timescale 1ns/1ps
module eesa_master #(
   parameter int SCL_QTR = eesa_pkg::SCL_QTR_CYC
) (
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RESET,
   // command
   input  wire logic       CMD_VALID,
   output logic            CMD_READY,
   input  wire logic       CMD_READ,
   input  wire logic [2:0] CMD_SELECT,
   input  wire logic [7:0] CMD_ADDR,
   input  wire logic [7:0] CMD_WDATA,
   // response
   output logic            RSP_VALID,
   output logic            RSP_ACKED,
   output logic [7:0]      RSP_RDATA,
   // bus
   eesa_if.host            BUS
);
   import eesa_pkg::*;

   localparam int QW = $clog2(SCL_QTR + 1);

   logic [QW-1:0] div_ff;
   logic          sda1_ff;
   logic          sda2_ff;
   eesa_mst_t     st_ff;
   logic [1:0]    ph_ff;
   logic [2:0]    step_ff;
   logic [3:0]    bit_ff;
   logic [7:0]    txb_ff;
   logic [7:0]    rxb_ff;
   logic          read_ff;
   logic [2:0]    sel_ff;
   logic [7:0]    addr_ff;
   logic [7:0]    wdat_ff;
   logic          acked_ff;
   logic          scl_ff;
   logic          oe_ff;
   logic          rsp_ff;
   logic          tick;
   logic [2:0]    nxt_step;
   eesa_op_t      nxt_op;
   logic          is_tx;

   function automatic eesa_op_t op_of(input logic [2:0] s, input logic rd);
      case (s)
         3'h0:    op_of = OP_START;
         3'h3:    op_of = rd ? OP_START : OP_TX;
         3'h4:    op_of = rd ? OP_TX : OP_STOP;
         3'h5:    op_of = OP_RX;
         3'h6:    op_of = OP_STOP;
         default: op_of = OP_TX;
      endcase
   endfunction : op_of

   function automatic logic [7:0] byte_of(input logic [2:0] s, input logic [2:0] sel,
                                          input logic [7:0] adr, input logic [7:0] wd);
      case (s)
         3'h1:    byte_of = {TYPE_CODE, sel, 1'b0};
         3'h2:    byte_of = adr;
         3'h3:    byte_of = wd;
         default: byte_of = {TYPE_CODE, sel, 1'b1};
      endcase
   endfunction : byte_of

   // quarter-period enable; the link clock is made here, not received
   assign tick     = div_ff == QW'(SCL_QTR - 1);
   assign nxt_step = step_ff + 3'h1;
   assign nxt_op   = op_of(nxt_step, read_ff);
   assign is_tx    = op_of(step_ff, read_ff) == OP_TX;

   always_ff @(posedge CLOCK)
   begin
      if (RESET || tick)
         div_ff <= '0;
      else
         div_ff <= div_ff + QW'(1);
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         sda1_ff <= 1'b1;
         sda2_ff <= 1'b1;
      end
      else
      begin
         sda1_ff <= BUS.sda;
         sda2_ff <= sda1_ff;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      rsp_ff <= 1'b0;
      if (RESET)
      begin
         st_ff    <= M_IDLE;
         ph_ff    <= 2'h0;
         step_ff  <= 3'h0;
         bit_ff   <= 4'h0;
         scl_ff   <= 1'b1;
         oe_ff    <= 1'b0;
         acked_ff <= 1'b0;
         rxb_ff   <= 8'h00;
      end
      else if (st_ff == M_IDLE)
      begin
         if (CMD_VALID)
         begin
            st_ff    <= M_START;
            ph_ff    <= 2'h0;
            step_ff  <= 3'h0;
            read_ff  <= CMD_READ;
            sel_ff   <= CMD_SELECT;
            addr_ff  <= CMD_ADDR;
            wdat_ff  <= CMD_WDATA;
            acked_ff <= 1'b1;
         end
      end
      else if (tick)
      begin
         ph_ff <= ph_ff + 2'h1;
         case (ph_ff)
            2'h0:
            begin
               scl_ff <= 1'b0;
               // let go with the falling clock so the slave's early acknowledge never meets us
               if (st_ff == M_XFER && bit_ff == BIT_ACK)
                  oe_ff <= 1'b0;
            end
            2'h1:
               // data moves only while the clock is low
               case (st_ff)
                  M_START: oe_ff <= 1'b0;
                  M_STOP:  oe_ff <= 1'b1;
                  default: oe_ff <= is_tx && bit_ff < BIT_ACK && !txb_ff[7];
               endcase
            2'h2:
               scl_ff <= 1'b1;
            default:
            begin
               if (st_ff == M_STOP)
               begin
                  oe_ff     <= 1'b0;
                  st_ff     <= M_IDLE;
                  rsp_ff    <= 1'b1;
               end
               else if (st_ff == M_XFER && bit_ff < BIT_ACK)
               begin
                  rxb_ff <= {rxb_ff[6:0], sda2_ff};
                  txb_ff <= {txb_ff[6:0], 1'b1};
                  bit_ff <= bit_ff + 4'h1;
               end
               else if (st_ff == M_XFER && is_tx && sda2_ff)
               begin
                  acked_ff <= 1'b0;
                  step_ff  <= read_ff ? RD_STOP_STEP : WR_STOP_STEP;
                  st_ff    <= M_STOP;
               end
               else
               begin
                  if (st_ff == M_START)
                     oe_ff <= 1'b1;
                  step_ff <= nxt_step;
                  bit_ff  <= 4'h0;
                  txb_ff  <= byte_of(nxt_step, sel_ff, addr_ff, wdat_ff);
                  case (nxt_op)
                     OP_START: st_ff <= M_START;
                     OP_STOP:  st_ff <= M_STOP;
                     default:  st_ff <= M_XFER;
                  endcase
               end
            end
         endcase
      end
   end

   assign CMD_READY   = st_ff == M_IDLE;
   assign RSP_VALID   = rsp_ff;
   assign RSP_ACKED   = acked_ff;
   assign RSP_RDATA   = rxb_ff;
   assign BUS.scl     = scl_ff;
   assign BUS.m_sda_o = 1'b0;
   assign BUS.m_sda_oe = oe_ff;
endmodule : eesa_master

/* File: design/eesa_pkg.sv */
// shared constants and types of the two-wire memory link
package eesa_pkg;
   // device type code, value is arbitrary
   localparam logic [3:0] TYPE_CODE     = 4'h5;
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         T_WR_STD_MS   = 10;
   localparam int         T_WR_LV_MS    = 15;
   localparam int         WR_STD_CYC    = T_WR_STD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         WR_LV_CYC     = T_WR_LV_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         SCL_KHZ       = 100;
   localparam int         SCL_QTR_CYC   = 1000000 / (SCL_KHZ * 4 * CLK_PERIOD_NS);
   localparam int         PAGE_BYTES    = 16;
   localparam int         BLK_BYTES     = 256;
   localparam int         NUM_BLKS      = 2;
   localparam int         ENTRY_W       = 17;
   localparam logic [3:0] BIT_LAST      = 4'h7;
   localparam logic [3:0] BIT_ACK       = 4'h8;
   localparam logic [4:0] SYNC_RST      = 5'h03;
   localparam logic [7:0] TX_IDLE       = 8'hff;
   localparam logic [2:0] WR_STOP_STEP  = 3'h4;
   localparam logic [2:0] RD_STOP_STEP  = 3'h6;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_DEV  = 6'h02,
      S_WADR = 6'h04,
      S_WDAT = 6'h08,
      S_RDAT = 6'h10,
      S_WSTP = 6'h20
   } eesa_dst_t;

   typedef enum logic [3:0] {
      M_IDLE  = 4'h1,
      M_START = 4'h2,
      M_XFER  = 4'h4,
      M_STOP  = 4'h8
   } eesa_mst_t;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_TX    = 2'h1,
      OP_RX    = 2'h2,
      OP_STOP  = 2'h3
   } eesa_op_t;
endpackage : eesa_pkg

/* File: design/eesa_slave.sv */
// memory end: slave addressing, page buffer and self-timed program cycle
`timescale 1ns/1ps
module eesa_slave #(
   parameter bit LOW_VOLTAGE = 1'b0,
   parameter int WR_CYCLES   = LOW_VOLTAGE ? eesa_pkg::WR_LV_CYC : eesa_pkg::WR_STD_CYC,
   parameter int PAGE_DEPTH  = eesa_pkg::PAGE_BYTES
) (
   // clock and reset
   input  wire logic CLOCK,
   input  wire logic RESET,
   // straps and protection
   input  wire logic SELECT_PIN_ONE,
   input  wire logic SELECT_PIN_TWO,
   input  wire logic WRITE_PROTECT,
   // status
   output logic      BUSY,
   // bus
   eesa_if.dev       BUS
);
   import eesa_pkg::*;

   localparam int TW = $clog2(WR_CYCLES + 1);

   logic [7:0]         mem [NUM_BLKS*BLK_BYTES];
   logic [4:0]         sync1_ff;
   logic [4:0]         sync2_ff;
   logic               scl_q_ff;
   logic               sda_q_ff;
   eesa_dst_t          st_ff;
   logic [3:0]         cnt_ff;
   logic [7:0]         shift_ff;
   logic [7:0]         tx_ff;
   logic               ack_ff;
   logic               mack_ff;
   logic               select_bit_zero_ff;
   logic [7:0]         addr_ff;
   logic               pend_ff;
   logic               busy_ff;
   logic [TW-1:0]      timer_ff;
   logic               oe_ff;
   logic               scl;
   logic               sda;
   logic               pin_one;
   logic               pin_two;
   logic               protect;
   logic               start_det;
   logic               stop_det;
   logic               rise_det;
   logic               fall_det;
   logic               dev_hit;
   logic               push;
   logic               buf_ready;
   logic               buf_valid;
   logic [ENTRY_W-1:0] buf_out;

   assign scl     = sync2_ff[0];
   assign sda     = sync2_ff[1];
   assign pin_one = sync2_ff[2];
   assign pin_two = sync2_ff[3];
   assign protect = sync2_ff[4] && select_bit_zero_ff;

   // pins cross into the clock domain before any use
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         sync1_ff <= SYNC_RST;
         sync2_ff <= SYNC_RST;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         sync1_ff <= {WRITE_PROTECT, SELECT_PIN_TWO, SELECT_PIN_ONE, BUS.sda, BUS.scl};
         sync2_ff <= sync1_ff;
         scl_q_ff <= sync2_ff[0];
         sda_q_ff <= sync2_ff[1];
      end
   end

   assign start_det = scl && scl_q_ff && sda_q_ff && !sda;
   assign stop_det  = scl && scl_q_ff && !sda_q_ff && sda;
   assign rise_det  = scl && !scl_q_ff;
   assign fall_det  = !scl && scl_q_ff;

   // type code, then strapped bits; bit 1 is the block, bit 0 the direction
   assign dev_hit = (shift_ff[7:4] == TYPE_CODE)
                    && (shift_ff[3] == pin_two) && (shift_ff[2] == pin_one);

   // a full page buffer or a guarded block refuses the data byte
   assign push = fall_det && (cnt_ff == BIT_LAST) && (st_ff == S_WDAT)
                 && !protect && buf_ready;

   always_ff @(posedge CLOCK)
   begin
      if (RESET || busy_ff)
      begin
         st_ff   <= S_IDLE;
         cnt_ff  <= '0;
         ack_ff  <= 1'b0;
         pend_ff <= 1'b0;
         mack_ff <= 1'b0;
         tx_ff   <= TX_IDLE;
      end
      else if (start_det)
      begin
         st_ff  <= S_DEV;
         // the clock fall that closes a start carries no bit; it wraps this to zero
         cnt_ff <= '1;
         ack_ff <= 1'b0;
         tx_ff  <= TX_IDLE;
      end
      else if (stop_det)
      begin
         st_ff   <= S_IDLE;
         cnt_ff  <= '0;
         ack_ff  <= 1'b0;
         pend_ff <= 1'b0;
         tx_ff   <= TX_IDLE;
      end
      else if (rise_det && cnt_ff != BIT_ACK)
         shift_ff <= {shift_ff[6:0], sda};
      else if (rise_det)
         mack_ff <= !sda;
      else if (fall_det && st_ff != S_IDLE && st_ff != S_WSTP)
      begin
         if (cnt_ff == BIT_LAST)
         begin
            cnt_ff <= BIT_ACK;
            tx_ff  <= {tx_ff[6:0], 1'b1};
            case (st_ff)
               S_DEV:
               begin
                  if (dev_hit)
                  begin
                     ack_ff             <= 1'b1;
                     select_bit_zero_ff <= shift_ff[1];
                     st_ff              <= shift_ff[0] ? S_RDAT : S_WADR;
                  end
                  else
                     st_ff <= S_IDLE;
               end
               S_WADR:
               begin
                  ack_ff  <= 1'b1;
                  addr_ff <= shift_ff;
                  st_ff   <= S_WDAT;
               end
               S_WDAT:
               begin
                  if (push)
                  begin
                     ack_ff       <= 1'b1;
                     addr_ff[3:0] <= addr_ff[3:0] + 4'h1;
                     pend_ff      <= 1'b1;
                  end
                  else
                     st_ff <= S_WSTP;
               end
               default:
                  ack_ff <= 1'b0;
            endcase
         end
         else if (cnt_ff == BIT_ACK)
         begin
            cnt_ff <= '0;
            ack_ff <= 1'b0;
            if (st_ff == S_RDAT)
            begin
               // own acknowledge of the address reads back as a master one
               if (mack_ff)
               begin
                  tx_ff   <= mem[{select_bit_zero_ff, addr_ff}];
                  addr_ff <= addr_ff + 8'h01;
               end
               else
               begin
                  st_ff <= S_WSTP;
                  tx_ff <= TX_IDLE;
               end
            end
         end
         else
         begin
            cnt_ff <= cnt_ff + 4'h1;
            tx_ff  <= {tx_ff[6:0], 1'b1};
         end
      end
   end

   // program cycle drains the page buffer while its timer runs
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         busy_ff  <= 1'b0;
         timer_ff <= '0;
      end
      else if (busy_ff)
      begin
         if (timer_ff != '0)
            timer_ff <= timer_ff - TW'(1);
         else if (!buf_valid)
            busy_ff <= 1'b0;
      end
      else if (stop_det && pend_ff)
      begin
         busy_ff  <= 1'b1;
         timer_ff <= TW'(WR_CYCLES - 1);
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (busy_ff && buf_valid)
         mem[buf_out[ENTRY_W-1:8]] <= buf_out[7:0];
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET || busy_ff)
         oe_ff <= 1'b0;
      else
         oe_ff <= ack_ff || (st_ff == S_RDAT && cnt_ff < BIT_ACK && !tx_ff[7]);
   end

   eesa_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (PAGE_DEPTH)
   ) u_page (
      .clk       (CLOCK),
      .rst       (RESET),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   ({select_bit_zero_ff, addr_ff, shift_ff}),
      .out_valid (buf_valid),
      .out_ready (busy_ff),
      .out_data  (buf_out)
   );

   assign BUS.s_sda_o  = 1'b0;
   assign BUS.s_sda_oe = oe_ff;
   assign BUSY         = busy_ff;
endmodule : eesa_slave

/* File: verif/eesa_monitor.sv */
// protocol checker on the shared two-wire link and the program-cycle flag
`timescale 1ns/1ps
module eesa_monitor #(
   parameter int WR_CYCLES = 2000,
   parameter int SCL_QTR   = 8
) (
   // clock and reset
   input  wire logic CLOCK,
   input  wire logic RESET,
   // link
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic m_sda_oe,
   input  wire logic s_sda_oe,
   // status
   input  wire logic BUSY
);
   localparam int QWIN     = 2 * SCL_QTR;
   localparam int STOP_LAG = 10;
   logic        scl_q_ff;
   logic        sda_q_ff;
   logic [3:0]  bit_cnt_ff;
   logic [3:0]  since_stop_ff;
   logic [31:0] busy_cnt_ff;
   logic        start_now;
   logic        stop_now;

   assign start_now = scl && scl_q_ff && sda_q_ff && !sda;
   assign stop_now  = scl && scl_q_ff && !sda_q_ff && sda;

   always_ff @(posedge CLOCK)
   begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
   end

   // bit position within the nine-clock byte frame
   always_ff @(posedge CLOCK)
   begin
      if (RESET || start_now)
         bit_cnt_ff <= 4'h0;
      else if (scl && !scl_q_ff)
         bit_cnt_ff <= (bit_cnt_ff == 4'h8) ? 4'h0 : bit_cnt_ff + 4'h1;
   end

   // saturates so a long idle bus never wraps back into the window
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
         since_stop_ff <= 4'hf;
      else if (stop_now)
         since_stop_ff <= 4'h0;
      else if (since_stop_ff != 4'hf)
         since_stop_ff <= since_stop_ff + 4'h1;
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET || !BUSY)
         busy_cnt_ff <= 32'h0;
      else
         busy_cnt_ff <= busy_cnt_ff + 32'h1;
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   sequence start_seq;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_seq;
      scl && $past(scl) && $rose(sda);
   endsequence

   chk_busy_quiet : assert property (BUSY |-> !s_sda_oe)
      else $error("memory end drives data while programming");
   chk_one_driver : assert property (!(m_sda_oe && s_sda_oe))
      else $error("both ends drive the data line");
   chk_slave_low_edge : assert property ($changed(s_sda_oe) |-> !scl)
      else $error("memory end changed data while clock high");
   chk_bit_stands : assert property (s_sda_oe && $rose(scl) |-> s_sda_oe [*8])
      else $error("driven low bit released during clock high");
   chk_start_hold : assert property (start_seq |-> scl [*4] ##[1:QWIN] !scl)
      else $error("start not followed by clock low in time");
   chk_start_released : assert property (start_seq |-> !s_sda_oe)
      else $error("memory end holds data at a start");
   chk_stop_idle : assert property (stop_seq |-> (scl && sda) [*4])
      else $error("bus not idle after stop");
   chk_ninth_release : assert property (scl && !scl_q_ff && bit_cnt_ff == 4'h8 |-> !m_sda_oe)
      else $error("master holds data in the acknowledge clock");
   chk_busy_after_stop : assert property ($rose(BUSY) |-> since_stop_ff <= STOP_LAG)
      else $error("program cycle began without a stop");
   chk_busy_length : assert property ($fell(BUSY) |-> busy_cnt_ff >= WR_CYCLES - 1
                                       && busy_cnt_ff <= WR_CYCLES + 20)
      else $error("program cycle length out of range");
endmodule : eesa_monitor

/* File: verif/test_serial_eeprom_slave_addressing.sv */
// self-checking bench: master end talks to memory end over the shared link
`timescale 1ns/1ps
module test_serial_eeprom_slave_addressing;
   import eesa_pkg::*;
   localparam int WR_CYC = 2000;
   localparam int QTR    = 8;
   logic        clock       = 1'b0;
   logic        reset       = 1'b1;
   logic        pin_one     = 1'b0;
   logic        pin_two     = 1'b1;
   logic        wp          = 1'b0;
   logic        cmd_valid   = 1'b0;
   logic        cmd_read    = 1'b0;
   logic [2:0]  cmd_sel     = 3'h0;
   logic [7:0]  cmd_addr    = 8'h00;
   logic [7:0]  cmd_wdata   = 8'h00;
   logic [15:0] rnd         = 16'hf0de;
   logic        busy;
   logic        cmd_ready;
   logic        rsp_valid;
   logic        rsp_acked;
   logic [7:0]  rsp_rdata;
   logic [7:0]  mem [int];
   int          bad_count   = 0;
   int          n_tests     = 0;
   int          cycles      = 0;

   eesa_if bus ();
   eesa_slave #(.WR_CYCLES(WR_CYC)) u_eesa_slave (.CLOCK(clock), .RESET(reset), .SELECT_PIN_ONE(pin_one),
      .SELECT_PIN_TWO(pin_two), .WRITE_PROTECT(wp), .BUSY(busy), .BUS(bus));
   eesa_master #(.SCL_QTR(QTR)) u_eesa_master (.CLOCK(clock), .RESET(reset), .CMD_VALID(cmd_valid),
      .CMD_READY(cmd_ready), .CMD_READ(cmd_read), .CMD_SELECT(cmd_sel), .CMD_ADDR(cmd_addr),
      .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_ACKED(rsp_acked), .RSP_RDATA(rsp_rdata), .BUS(bus));
   eesa_monitor #(.WR_CYCLES(WR_CYC), .SCL_QTR(QTR)) u_eesa_monitor (.CLOCK(clock), .RESET(reset),
      .scl(bus.scl), .sda(bus.sda), .m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe), .BUSY(busy));

   initial
   begin
      forever #5 clock = ~clock;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : check

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // one command through the master end; the model decides who must acknowledge
   task automatic run_cmd(input logic rd, input logic [2:0] sel, input logic [7:0] adr, input logic [7:0] wd,
                          input logic busy_exp);
      logic ok;
      logic ack_exp;
      int   n;
      ack_exp = (sel[2:1] == {pin_two, pin_one}) && !busy_exp && !(!rd && sel[0] && wp);
      cmd_read = rd;
      cmd_sel = sel;
      cmd_addr = adr;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      ok = 1'b0;
      while (!ok)
      begin
         ok = cmd_ready;
         @(posedge clock);
         #1;
      end
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4000)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      check("response", 1'b1, rsp_valid);
      check("acknowledge", ack_exp, rsp_acked);
      if (rd && ack_exp)
         check("read data", mem[{sel[0], adr}], rsp_rdata);
      if (!rd && ack_exp)
      begin
         mem[{sel[0], adr}] = wd;
         // the memory end sees the stop only after its synchroniser
         repeat (4) @(posedge clock);
         #1;
         check("program start", 1'b1, busy);
      end
   endtask : run_cmd

   task automatic wait_prog();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < WR_CYC + 200)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      check("program end", 1'b0, busy);
   endtask : wait_prog

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (8) @(posedge clock);
      #1;
      reset = 1'b0;
      // idle ends after reset; the page buffer is exercised by every acknowledged write, each read back except the 8'h3c write to block 0
      check("idle busy", 1'b0, busy);
      check("idle ready", 1'b1, cmd_ready);
      check("idle acknowledge", 1'b0, rsp_acked);
      // both page blocks, random array addresses and data
      for (int k = 0; k < 4; k++)
      begin
         rnd = lfsr_next(rnd);
         run_cmd(1'b0, {2'b10, k[0]}, rnd[7:0], rnd[15:8], 1'b0);
         wait_prog();
         run_cmd(1'b1, {2'b10, k[0]}, rnd[7:0], 8'h00, 1'b0);
      end
      wp = 1'b1;
      run_cmd(1'b0, 3'b101, rnd[7:0], ~rnd[15:8], 1'b0);
      run_cmd(1'b1, 3'b101, rnd[7:0], 8'h00, 1'b0);
      run_cmd(1'b0, 3'b100, rnd[7:0], 8'h3c, 1'b0);
      wait_prog();
      wp = 1'b0;
      run_cmd(1'b0, 3'b010, 8'h11, 8'h22, 1'b0);
      run_cmd(1'b1, 3'b110, 8'h11, 8'h00, 1'b0);
      pin_one = 1'b1;
      run_cmd(1'b0, 3'b111, 8'hff, 8'ha5, 1'b0);
      run_cmd(1'b1, 3'b111, 8'hff, 8'h00, 1'b1);
      wait_prog();
      run_cmd(1'b1, 3'b111, 8'hff, 8'h00, 1'b0);
      print_verdict();
   end
endmodule : test_serial_eeprom_slave_addressing
